// [hdl/sensor_cfg_pkg.sv]
package sensor_cfg_pkg;
    // Bus and word widths
    localparam int WB_AW = 10;
    localparam int WB_DW = 32;
    localparam int REG_W = 16;
    localparam int IDX_W = 8;
    localparam int SEL_W = 4;
    localparam int NUM_DATA_LANES = 4;

    // Register indices; byte address is index times four
    localparam logic [IDX_W-1:0] IDX_BIAS     = 8'h44;
    localparam logic [IDX_W-1:0] IDX_RSV_BIAS = 8'h46;
    localparam logic [IDX_W-1:0] IDX_CP       = 8'h48;
    localparam logic [IDX_W-1:0] IDX_RSV_A    = 8'h50;
    localparam logic [IDX_W-1:0] IDX_RSV_B    = 8'h51;
    localparam logic [IDX_W-1:0] IDX_RSV_C    = 8'h60;
    localparam logic [IDX_W-1:0] IDX_RSV_D    = 8'h61;
    localparam logic [IDX_W-1:0] IDX_PWR      = 8'h70;
    localparam logic [IDX_W-1:0] IDX_BCAL     = 8'h80;

    // Reset values
    localparam logic [REG_W-1:0] RST_BIAS     = 16'h0088;
    localparam logic [REG_W-1:0] RST_RSV_BIAS = 16'h8888;
    localparam logic [REG_W-1:0] RST_CP       = 16'h1200;
    localparam logic [REG_W-1:0] RST_RSV_A    = 16'h0000;
    localparam logic [REG_W-1:0] RST_RSV_B    = 16'h8881;
    localparam logic [REG_W-1:0] RST_RSV_C    = 16'h0000;
    localparam logic [REG_W-1:0] RST_RSV_D    = 16'h0000;
    localparam logic [REG_W-1:0] RST_PWR      = 16'h0000;
    localparam logic [REG_W-1:0] RST_BCAL     = 16'h4008;

    // Writable bits; the rest read as zero
    localparam logic [REG_W-1:0] MSK_BIAS     = 16'h00FF;
    localparam logic [REG_W-1:0] MSK_RSV_BIAS = 16'hFFFF;
    localparam logic [REG_W-1:0] MSK_CP       = 16'h7703;
    localparam logic [REG_W-1:0] MSK_RSV_A    = 16'h03FF;
    localparam logic [REG_W-1:0] MSK_RSV_B    = 16'hFFFF;
    localparam logic [REG_W-1:0] MSK_RSV_C    = 16'h003F;
    localparam logic [REG_W-1:0] MSK_PWR      = 16'h0007;
    localparam logic [REG_W-1:0] MSK_BCAL     = 16'hFFFF;

    // Field positions
    localparam int PWR_CLK_BIT   = 0;
    localparam int PWR_SYNC_BIT  = 1;
    localparam int PWR_DATA_BIT  = 2;
    localparam int CP_PD_EN_BIT  = 0;
    localparam int CP_FD_EN_BIT  = 1;
    localparam int CP_PD_TRIM_LO = 8;
    localparam int CP_FD_TRIM_LO = 12;
    localparam int TRIM_W        = 3;
    localparam int BCAL_LVL_LO   = 0;
    localparam int BCAL_LVL_W    = 8;
    localparam int BCAL_SMP_LO   = 8;
    localparam int BCAL_SMP_W    = 3;
    localparam int BIAS_IB_LO    = 0;
    localparam int BIAS_IR_LO    = 4;
    localparam int BIAS_W        = 4;
    localparam int SMP_CNT_W     = 8;
    localparam logic [SMP_CNT_W-1:0] RST_SMP_CNT = 8'h01;

    // Bus handshake states
    typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;
endpackage

// [hdl/reg_access_if.sv]
`timescale 1ns/10ps
interface reg_access_if import sensor_cfg_pkg::*; ();
    logic             req;
    logic             we;
    logic [IDX_W-1:0] idx;
    logic [REG_W-1:0] wdata;
    logic [1:0]       sel;
    logic             ack;

    modport port_side (output req, we, idx, wdata, sel, ack);
    modport reg_side  (input req, we, idx, wdata, sel, ack);
endinterface

// [hdl/wb_reg_port.sv]
`timescale 1ns/10ps
module wb_reg_port import sensor_cfg_pkg::*; (
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst_b,
    input  wire logic             i_wb_cyc,
    input  wire logic             i_wb_stb,
    input  wire logic             i_wb_we,
    input  wire logic [WB_AW-1:0] i_wb_adr,
    input  wire logic [WB_DW-1:0] i_wb_dat,
    input  wire logic [SEL_W-1:0] i_wb_sel,
    reg_access_if.port_side       bus
);
    typedef struct packed {
        bus_state_t st;
        logic       ack;
    } port_state_t;

    port_state_t s_q;
    port_state_t s_d;
    logic        req;

    // One request per cycle/strobe; held strobe during ack is not re-taken
    assign req = (s_q.st == BUS_IDLE) && i_wb_cyc && i_wb_stb;

    always_comb begin
        s_d = s_q;
        case (s_q.st)
            BUS_IDLE: begin
                s_d.ack = req;
                if (req) begin
                    s_d.st = BUS_ACK;
                end
            end
            BUS_ACK: begin
                s_d.ack = 1'b0;
                s_d.st  = BUS_IDLE;
            end
            default: begin
                s_d.ack = 1'b0;
                s_d.st  = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_q <= '{st: BUS_IDLE, ack: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // Word index drops the byte offset bits
    assign bus.req   = req;
    assign bus.we    = i_wb_we;
    assign bus.idx   = i_wb_adr[WB_AW-1:2];
    assign bus.wdata = i_wb_dat[REG_W-1:0];
    assign bus.sel   = i_wb_sel[1:0];
    assign bus.ack   = s_q.ack;

    chk_ack_after_req: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        req |=> s_q.ack && !req) else $error("ack did not follow request");
    chk_ack_one_cycle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        s_q.ack |=> !s_q.ack) else $error("ack held longer than one cycle");
endmodule // wb_reg_port

// [hdl/sensor_cfg_regs.sv]
// Our own choice: the Wishbone slave port.
`timescale 1ns/10ps
module sensor_cfg_regs import sensor_cfg_pkg::*; #(
    parameter int NUM_LANES = NUM_DATA_LANES
) (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rst_b,
    input  wire logic                  i_wb_cyc,
    input  wire logic                  i_wb_stb,
    input  wire logic                  i_wb_we,
    input  wire logic [WB_AW-1:0]      i_wb_adr,
    input  wire logic [WB_DW-1:0]      i_wb_dat,
    input  wire logic [SEL_W-1:0]      i_wb_sel,
    output logic      [WB_DW-1:0]      o_wb_dat,
    output logic                       o_wb_ack,
    output logic                       o_clk_lane_pwr_up,
    output logic                       o_sync_lane_pwr_up,
    output logic      [NUM_LANES-1:0]  o_data_lane_pwr_up,
    output logic                       o_pd_pump_en,
    output logic                       o_fd_pump_en,
    output logic      [TRIM_W-1:0]     o_pd_pump_trim,
    output logic      [TRIM_W-1:0]     o_fd_pump_trim,
    output logic      [BCAL_LVL_W-1:0] o_black_level,
    output logic      [BCAL_SMP_W-1:0] o_black_samples_log2,
    output logic      [SMP_CNT_W-1:0]  o_black_sample_count,
    output logic      [BIAS_W-1:0]     o_serial_bias_code,
    output logic      [BIAS_W-1:0]     o_serial_ref_code
);
    typedef struct packed {
        logic [REG_W-1:0]     bias;
        logic [REG_W-1:0]     rsv_bias;
        logic [REG_W-1:0]     cp;
        logic [REG_W-1:0]     rsv_a;
        logic [REG_W-1:0]     rsv_b;
        logic [REG_W-1:0]     rsv_c;
        logic [REG_W-1:0]     pwr;
        logic [REG_W-1:0]     bcal;
        logic [SMP_CNT_W-1:0] smp_cnt;
        logic [REG_W-1:0]     rdat;
    } cfg_state_t;

    localparam cfg_state_t STATE_RST = '{
        bias:     RST_BIAS,
        rsv_bias: RST_RSV_BIAS,
        cp:       RST_CP,
        rsv_a:    RST_RSV_A,
        rsv_b:    RST_RSV_B,
        rsv_c:    RST_RSV_C,
        pwr:      RST_PWR,
        bcal:     RST_BCAL,
        smp_cnt:  RST_SMP_CNT,
        rdat:     16'h0000
    };

    cfg_state_t s_q;
    cfg_state_t s_d;

    reg_access_if ra ();

    // Bus handshake and address split live in the port block
    wb_reg_port u_port (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (i_rst_b),
        .i_wb_cyc  (i_wb_cyc),
        .i_wb_stb  (i_wb_stb),
        .i_wb_we   (i_wb_we),
        .i_wb_adr  (i_wb_adr),
        .i_wb_dat  (i_wb_dat),
        .i_wb_sel  (i_wb_sel),
        .bus       (ra.port_side)
    );

    // Byte-lane merge; bits outside the mask stay zero
    function automatic logic [REG_W-1:0] merge(
        input logic [REG_W-1:0] old,
        input logic [REG_W-1:0] wd,
        input logic [1:0]       sel,
        input logic [REG_W-1:0] msk
    );
        logic [REG_W-1:0] lane;
        lane = {{8{sel[1]}}, {8{sel[0]}}};
        return ((wd & lane) | (old & ~lane)) & msk;
    endfunction

    // Read mux; unmapped indices and the read-only spare word give zero
    function automatic logic [REG_W-1:0] read_word(
        input cfg_state_t       s,
        input logic [IDX_W-1:0] idx
    );
        logic [REG_W-1:0] r;
        r = 16'h0000;
        case (idx)
            IDX_BIAS:     r = s.bias;
            IDX_RSV_BIAS: r = s.rsv_bias;
            IDX_CP:       r = s.cp;
            IDX_RSV_A:    r = s.rsv_a;
            IDX_RSV_B:    r = s.rsv_b;
            IDX_RSV_C:    r = s.rsv_c;
            IDX_RSV_D:    r = RST_RSV_D;
            IDX_PWR:      r = s.pwr;
            IDX_BCAL:     r = s.bcal;
            default:      r = 16'h0000;
        endcase
        return r;
    endfunction

    // Writes land at the edge the request is taken, same edge ack rises
    always_comb begin
        s_d = s_q;
        if (ra.req && ra.we) begin
            s_d.rdat = 16'h0000;
            case (ra.idx)
                IDX_BIAS: begin
                    s_d.bias = merge(s_q.bias, ra.wdata, ra.sel, MSK_BIAS);
                end
                IDX_RSV_BIAS: begin
                    s_d.rsv_bias = merge(s_q.rsv_bias, ra.wdata, ra.sel, MSK_RSV_BIAS);
                end
                IDX_CP: begin
                    s_d.cp = merge(s_q.cp, ra.wdata, ra.sel, MSK_CP);
                end
                IDX_RSV_A: begin
                    s_d.rsv_a = merge(s_q.rsv_a, ra.wdata, ra.sel, MSK_RSV_A);
                end
                IDX_RSV_B: begin
                    s_d.rsv_b = merge(s_q.rsv_b, ra.wdata, ra.sel, MSK_RSV_B);
                end
                IDX_RSV_C: begin
                    s_d.rsv_c = merge(s_q.rsv_c, ra.wdata, ra.sel, MSK_RSV_C);
                end
                IDX_PWR: begin
                    s_d.pwr = merge(s_q.pwr, ra.wdata, ra.sel, MSK_PWR);
                end
                IDX_BCAL: begin
                    s_d.bcal = merge(s_q.bcal, ra.wdata, ra.sel, MSK_BCAL);
                end
                default: begin
                    s_d.rdat = 16'h0000;
                end
            endcase
        end else if (ra.req) begin
            s_d.rdat = read_word(s_q, ra.idx);
        end
        // Sample count is registered so the data path sees a flop
        s_d.smp_cnt = SMP_CNT_W'(8'h01 << s_d.bcal[BCAL_SMP_LO +: BCAL_SMP_W]);
    end

    // Everything returns to documented defaults on reset
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_q <= STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Bus answer
    assign o_wb_dat = {16'h0000, s_q.rdat};
    assign o_wb_ack = ra.ack;

    // Lane power controls, low means powered down
    assign o_clk_lane_pwr_up  = s_q.pwr[PWR_CLK_BIT];
    assign o_sync_lane_pwr_up = s_q.pwr[PWR_SYNC_BIT];

    // One shared control fans out to every data lane
    for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
        assign o_data_lane_pwr_up[g] = s_q.pwr[PWR_DATA_BIT];
    end

    // Charge pumps
    assign o_pd_pump_en   = s_q.cp[CP_PD_EN_BIT];
    assign o_fd_pump_en   = s_q.cp[CP_FD_EN_BIT];
    assign o_pd_pump_trim = s_q.cp[CP_PD_TRIM_LO +: TRIM_W];
    assign o_fd_pump_trim = s_q.cp[CP_FD_TRIM_LO +: TRIM_W];

    // Black calibration controls
    assign o_black_level        = s_q.bcal[BCAL_LVL_LO +: BCAL_LVL_W];
    assign o_black_samples_log2 = s_q.bcal[BCAL_SMP_LO +: BCAL_SMP_W];
    assign o_black_sample_count = s_q.smp_cnt;

    // Serial output bias codes
    assign o_serial_bias_code = s_q.bias[BIAS_IB_LO +: BIAS_W];
    assign o_serial_ref_code  = s_q.bias[BIAS_IR_LO +: BIAS_W];

    // Helper: power word untouched since reset
    logic pwr_wr;
    logic pwr_seen_q;
    assign pwr_wr = ra.req && ra.we && ra.idx == IDX_PWR && ra.sel[0];
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pwr_seen_q <= 1'b0;
        end else if (pwr_wr) begin
            pwr_seen_q <= 1'b1;
        end
    end

    // Helper: low only in the first cycle after reset, before any write can land
    logic alive_q;
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            alive_q <= 1'b0;
        end else begin
            alive_q <= 1'b1;
        end
    end

    // Checks; the hold checks catch a write leaking into the wrong word
    chk_clk_lane_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        pwr_wr |=> o_clk_lane_pwr_up == $past(ra.wdata[0]))
        else $error("clock lane power does not follow write");
    chk_sync_lane_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        pwr_wr |=> o_sync_lane_pwr_up == $past(ra.wdata[1]))
        else $error("sync lane power does not follow write");
    chk_data_lanes_all: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        pwr_wr |=> o_data_lane_pwr_up == {NUM_LANES{$past(ra.wdata[2])}})
        else $error("data lanes not powered together");
    chk_lanes_reset_down: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        !pwr_seen_q |-> !o_clk_lane_pwr_up && !o_sync_lane_pwr_up
        && o_data_lane_pwr_up == '0)
        else $error("lane powered up without a write");
    chk_lane_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        !pwr_wr |=> $stable(o_clk_lane_pwr_up) && $stable(o_sync_lane_pwr_up)
        && $stable(o_data_lane_pwr_up))
        else $error("lane power changed without a write");
    chk_pumps_enable: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        ra.req && ra.we && ra.idx == IDX_CP && ra.sel[0] |=>
        {o_fd_pump_en, o_pd_pump_en} == $past(ra.wdata[1:0]))
        else $error("pump enable does not follow write");
    chk_pump_en_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        !(ra.req && ra.we && ra.idx == IDX_CP && ra.sel[0]) |=>
        $stable(o_pd_pump_en) && $stable(o_fd_pump_en))
        else $error("pump enable changed without a write");
    chk_pump_reset: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        !alive_q |-> !o_pd_pump_en && !o_fd_pump_en
        && o_pd_pump_trim == RST_CP[CP_PD_TRIM_LO +: TRIM_W]
        && o_fd_pump_trim == RST_CP[CP_FD_TRIM_LO +: TRIM_W])
        else $error("pump controls not at reset value");
    chk_trim_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        !(ra.req && ra.we && ra.idx == IDX_CP) |=> $stable(o_pd_pump_trim)
        && $stable(o_fd_pump_trim))
        else $error("trim changed without a write");
    chk_trim_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        ra.req && ra.we && ra.idx == IDX_CP && ra.sel[1] |=>
        o_pd_pump_trim == $past(ra.wdata[10:8]) && o_fd_pump_trim == $past(ra.wdata[14:12]))
        else $error("trim does not follow write");
    chk_black_level: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        ra.req && ra.we && ra.idx == IDX_BCAL && ra.sel[0] |=>
        o_black_level == $past(ra.wdata[7:0]))
        else $error("black level does not follow write");
    chk_sample_count: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        ra.req && ra.we && ra.idx == IDX_BCAL && ra.sel[1] |=>
        o_black_sample_count == SMP_CNT_W'(8'h01 << $past(ra.wdata[10:8])))
        else $error("sample count not two to the power");
    chk_count_log2: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        o_black_sample_count == SMP_CNT_W'(8'h01 << o_black_samples_log2))
        else $error("sample count disagrees with exponent");
    chk_black_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        !(ra.req && ra.we && ra.idx == IDX_BCAL) |=> $stable(o_black_level)
        && $stable(o_black_samples_log2) && $stable(o_black_sample_count))
        else $error("black controls changed without a write");
    chk_black_reset: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        !alive_q |-> o_black_level == RST_BCAL[BCAL_LVL_LO +: BCAL_LVL_W]
        && o_black_samples_log2 == RST_BCAL[BCAL_SMP_LO +: BCAL_SMP_W]
        && o_black_sample_count == RST_SMP_CNT)
        else $error("black controls not at reset value");
    chk_bias_readback: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        ra.req && !ra.we && ra.idx == IDX_BIAS |=> o_wb_ack
        && o_wb_dat[7:0] == {o_serial_ref_code, o_serial_bias_code})
        else $error("bias readback mismatch");
    chk_bias_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        ra.req && ra.we && ra.idx == IDX_BIAS && ra.sel[0] |=>
        {o_serial_ref_code, o_serial_bias_code} == $past(ra.wdata[7:0]))
        else $error("bias codes do not follow write");
    chk_bias_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        !(ra.req && ra.we && ra.idx == IDX_BIAS && ra.sel[0]) |=>
        $stable(o_serial_ref_code) && $stable(o_serial_bias_code))
        else $error("bias codes changed without a write");
    chk_bias_reset: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        !alive_q |-> o_serial_bias_code == RST_BIAS[BIAS_IB_LO +: BIAS_W]
        && o_serial_ref_code == RST_BIAS[BIAS_IR_LO +: BIAS_W])
        else $error("bias codes not at reset value");
    chk_ro_word_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        ra.req && !ra.we && ra.idx == IDX_RSV_D |=> o_wb_ack && o_wb_dat == '0)
        else $error("read-only spare word not zero");

    cov_pwr_write: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        pwr_wr ##1 o_data_lane_pwr_up[0]);
    cov_cp_read: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        ra.req && !ra.we && ra.idx == IDX_CP);
    cov_bcal_max: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        o_black_samples_log2 == 3'h7);
    cov_ro_write: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        ra.req && ra.we && ra.idx == IDX_RSV_D);
    cov_pumps_both: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        o_pd_pump_en && o_fd_pump_en);
endmodule // sensor_cfg_regs

// [verification/wb_host_model.sv]
`timescale 1ns/10ps
// Host side of the register bus: one classic Wishbone cycle at a time
module wb_host_model import sensor_cfg_pkg::*; (
    input  wire logic             i_clk_sys,
    input  wire logic             i_wb_ack,
    input  wire logic [WB_DW-1:0] i_wb_dat,
    output logic                  o_wb_cyc,
    output logic                  o_wb_stb,
    output logic                  o_wb_we,
    output logic      [WB_AW-1:0] o_wb_adr,
    output logic      [WB_DW-1:0] o_wb_dat,
    output logic      [SEL_W-1:0] o_wb_sel
);
    // Idle bus from time zero
    initial begin
        o_wb_cyc = 1'b0;
        o_wb_stb = 1'b0;
        o_wb_we  = 1'b0;
        o_wb_adr = '0;
        o_wb_dat = '0;
        o_wb_sel = '0;
    end

    // Request held until ack is seen at an edge; bounded so a dead slave cannot hang us.
    // Callers keep reserved words at reset value, apart from deliberate refusal
    task automatic xfer(input logic we, input logic [WB_AW-1:0] adr,
                        input logic [WB_DW-1:0] dat, input logic [SEL_W-1:0] sel,
                        output logic [WB_DW-1:0] rdat, output bit ok);
        int n;
        ok   = 1'b0;
        rdat = '0;
        @(posedge i_clk_sys);
        o_wb_cyc <= 1'b1;
        o_wb_stb <= 1'b1;
        o_wb_we  <= we;
        o_wb_adr <= adr;
        o_wb_dat <= dat;
        o_wb_sel <= sel;
        for (n = 0; n < 16 && !ok; n++) begin
            @(posedge i_clk_sys);
            if (i_wb_ack === 1'b1) begin
                ok   = 1'b1;
                rdat = i_wb_dat;
            end
        end
        // Released lines show inverted junk, so stale values never look valid
        o_wb_cyc <= 1'b0;
        o_wb_stb <= 1'b0;
        o_wb_we  <= ~we;
        o_wb_adr <= ~adr;
        o_wb_dat <= ~dat;
        o_wb_sel <= ~sel;
    endtask
endmodule // wb_host_model

// [verification/tb_top.sv]
`timescale 1ns/10ps
module tb_top import sensor_cfg_pkg::*;;
    logic                  i_clk_sys;
    logic                  i_rst_b;
    logic                  cyc, stb, we, ack;
    logic [WB_AW-1:0]      adr;
    logic [WB_DW-1:0]      wdat, rdat;
    logic [SEL_W-1:0]      sel;
    logic                  clk_up, sync_up, pd_en, fd_en;
    logic [3:0]            data_up;
    logic [2:0]            pd_trim, fd_trim, smp_log2;
    logic [7:0]            blk_lvl, smp_cnt;
    logic [3:0]            ib_code, ir_code;
    int                    n_mismatch;
    int                    compares;

    // Register map: byte address and reset value
    localparam logic [9:0]  adr_tab [9] = '{10'h110, 10'h118, 10'h120, 10'h140, 10'h144,
                                            10'h180, 10'h184, 10'h1C0, 10'h200};
    localparam logic [15:0] rst_tab [9] = '{16'h0088, 16'h8888, 16'h1200, 16'h0000, 16'h8881,
                                            16'h0000, 16'h0000, 16'h0000, 16'h4008};

    // 20 MHz system clock
    initial i_clk_sys = 1'b0;
    always #25 i_clk_sys = ~i_clk_sys;

    wb_host_model i_wb_host_model (.i_clk_sys(i_clk_sys), .i_wb_ack(ack), .i_wb_dat(rdat),
        .o_wb_cyc(cyc), .o_wb_stb(stb), .o_wb_we(we), .o_wb_adr(adr), .o_wb_dat(wdat),
        .o_wb_sel(sel));

    sensor_cfg_regs i_sensor_cfg_regs (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
        .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack), .o_clk_lane_pwr_up(clk_up),
        .o_sync_lane_pwr_up(sync_up), .o_data_lane_pwr_up(data_up), .o_pd_pump_en(pd_en),
        .o_fd_pump_en(fd_en), .o_pd_pump_trim(pd_trim), .o_fd_pump_trim(fd_trim),
        .o_black_level(blk_lvl), .o_black_samples_log2(smp_log2),
        .o_black_sample_count(smp_cnt), .o_serial_bias_code(ib_code),
        .o_serial_ref_code(ir_code));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("mismatches %0d, compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // One bus cycle; a missing ack ends the run
    task automatic bus(input logic w, input logic [9:0] a, input logic [15:0] d,
                       input logic [3:0] s, output logic [31:0] r);
        bit ok;
        i_wb_host_model.xfer(w, a, {16'h0000, d}, s, r, ok);
        if (!ok) begin
            n_mismatch++;
            test_done();
        end
    endtask

    // Write, then let the config outputs settle before any look
    task automatic wr(input logic [9:0] a, input logic [15:0] d, input logic [3:0] s);
        logic [31:0] r;
        bus(1'b1, a, d, s, r);
        @(negedge i_clk_sys);
    endtask

    task automatic rd_chk(input logic [9:0] a, input logic [15:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 16'h0000, 4'hF, r);
        check(r, {16'h0000, exp});
    endtask

    // Outputs and every register at their reset values, unmapped reads zero
    task automatic t_reset();
        @(negedge i_clk_sys);
        check({data_up, sync_up, clk_up}, 32'h0);
        check({pd_en, fd_en}, 32'h0);
        check({pd_trim, fd_trim}, {3'h2, 3'h1});
        check({blk_lvl, smp_log2, smp_cnt}, {8'h08, 3'h0, 8'h01});
        check({ir_code, ib_code}, 32'h88);
        for (int i = 0; i < 9; i++) rd_chk(adr_tab[i], rst_tab[i]);
        rd_chk(10'h3FC, 16'h0000);
    endtask

    // Every lane code, with junk above the mask
    task automatic t_power();
        logic [2:0] v;
        for (int i = 0; i < 8; i++) begin
            v = i[2:0];
            wr(10'h1C0, 16'hFFF8 | {13'h0, v}, 4'h3);
            check({data_up, sync_up, clk_up}, {{4{v[2]}}, v[1], v[0]});
            rd_chk(10'h1C0, {13'h0, v});
        end
    endtask

    // Pump enables one at a time, byte lanes written separately
    task automatic t_pump();
        wr(10'h120, 16'h0001, 4'h3);
        check({pd_en, fd_en}, 32'h2);
        wr(10'h120, 16'h0002, 4'h3);
        check({pd_en, fd_en}, 32'h1);
        wr(10'h120, 16'hFFFF, 4'h3);
        check({pd_en, fd_en, pd_trim, fd_trim}, {2'h3, 3'h7, 3'h7});
        wr(10'h120, 16'h0000, 4'h1);
        check({pd_en, fd_en, pd_trim, fd_trim}, {2'h0, 3'h7, 3'h7});
        rd_chk(10'h120, 16'h7700);
        wr(10'h120, 16'h5300, 4'h2);
        check({pd_trim, fd_trim}, {3'h3, 3'h5});
    endtask

    // Every sample exponent with a changing target level
    task automatic t_bcal();
        logic [7:0] lvl;
        for (int n = 0; n < 8; n++) begin
            lvl = 8'(n * 37 + 5);
            wr(10'h200, {5'h00, n[2:0], lvl}, 4'h3);
            check({blk_lvl, smp_log2, smp_cnt}, {lvl, n[2:0], 8'(1 << n)});
        end
    endtask

    // Bias codes through the low byte lane only; read-only word refuses a write
    task automatic t_bias_ro();
        wr(10'h110, 16'hFFA5, 4'h1);
        check({ir_code, ib_code}, 32'hA5);
        rd_chk(10'h110, 16'h00A5);
        wr(10'h184, 16'hFFFF, 4'h3);
        rd_chk(10'h184, 16'h0000);
        wr(10'h3FC, 16'hFFFF, 4'h3);
        rd_chk(10'h3FC, 16'h0000);
    endtask

    // Main sequence: reset held 8 cycles, then each scenario
    initial begin
        n_mismatch = 0;
        compares   = 0;
        i_rst_b    = 1'b0;
        repeat (8) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        t_reset();
        t_power();
        t_pump();
        t_bcal();
        t_bias_ro();
        test_done();
    end
endmodule // tb_top
